//--- flag_exec_unit.sv
//******************************************************************************
// Purpose: Executes shift, divide, stack, branch, loop, power and pointer ops
// Assumes: Sync active-high reset, 100 MHz clock, inputs synchronous
// Notes: Flags marked undefined are left unchanged
//******************************************************************************
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module flag_exec_unit
  import flag_exec_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Instruction stream
  input wire instr_t i_op,
  output exec_out_t o_exec,
  // Register port
  input wire bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // Core events
  input wire logic i_irq,
  input wire logic i_dma_req,
  input wire logic i_dma_done,
  // Status
  output logic [7:0] o_flags,
  output logic o_mem_space,
  output logic o_dma_ack,
  output cpu_state_t o_state
);

  //****************************************************************************
  // State
  //****************************************************************************
  typedef struct packed {
    cpu_state_t state;
    logic [7:0] flags;
    logic [7:0] rp_low;
    logic [7:0] rp_high;
    logic [7:0] sys_sp;
    logic [7:0] user_sp;
    logic [7:0] rdata;
    exec_out_t exec;
    logic dma_ack;
  } unit_state_t;

  unit_state_t st;
  unit_state_t next_st;

  function automatic logic top_bit(input logic [15:0] v, input logic word);
    return word ? v[15] : v[7];
  endfunction

  function automatic logic is_zero(input logic [15:0] v, input logic word);
    return word ? (v == 16'h0000) : (v[7:0] == 8'h00);
  endfunction

  // Only C, Z, S and V take part; D and H never steer a jump
  function automatic logic cond_met(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    c = f[C_BIT];
    z = f[Z_BIT];
    s = f[S_BIT];
    v = f[V_BIT];
    case (cc)
      CC_FALSE: return 1'b0;
      CC_TRUE: return 1'b1;
      CC_C: return c;
      CC_NC: return !c;
      CC_Z: return z;
      CC_NZ: return !z;
      CC_PL: return !s;
      CC_MI: return s;
      CC_OV: return v;
      CC_NOV: return !v;
      CC_GE: return !(s ^ v);
      CC_LT: return s ^ v;
      CC_GT: return !(z | (s ^ v));
      CC_LE: return z | (s ^ v);
      CC_UGT: return !c && !z;
      CC_ULE: return c | z;
      default: return 1'b0;
    endcase
  endfunction

  //****************************************************************************
  // Next-state logic
  //****************************************************************************
  always_comb
  begin
    logic [15:0] a;
    logic [15:0] res;
    logic [15:0] quot;
    logic [16:0] trial;
    logic w;
    logic cin;
    logic eq;
    logic take;
    a = i_op.a;
    res = 16'h0000;
    quot = 16'h0000;
    trial = 17'h00000;
    w = i_op.word;
    cin = st.flags[C_BIT];
    eq = w ? (i_op.a == i_op.b) : (i_op.a[7:0] == i_op.b[7:0]);
    take = i_op.valid && (st.state == RUNNING);
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.exec.done = 1'b0;
    next_st.exec.branch = 1'b0;
    next_st.exec.postinc = 1'b0;
    next_st.exec.stack_access = 1'b0;

    // Register port; an instruction in the same cycle overrides the flag bits it updates
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        FLAG_REG_ADDR: next_st.rdata = st.flags;
        RP_LOW_ADDR: next_st.rdata = st.rp_low;
        RP_HIGH_ADDR: next_st.rdata = st.rp_high;
        SYS_SP_ADDR: next_st.rdata = st.sys_sp;
        USER_SP_ADDR: next_st.rdata = st.user_sp;
        STATUS_ADDR: next_st.rdata = {6'h00, st.state};
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        FLAG_REG_ADDR: next_st.flags = i_bus.wdata;
        RP_LOW_ADDR: next_st.rp_low = i_bus.wdata;
        RP_HIGH_ADDR: next_st.rp_high = i_bus.wdata;
        SYS_SP_ADDR: next_st.sys_sp = i_bus.wdata;
        USER_SP_ADDR: next_st.user_sp = i_bus.wdata;
        default: ;
      endcase
    end

    // Power states
    case (st.state)
      WAITING:
      begin
        if (i_dma_req)
          next_st.state = DMA_SERVICE;
        else if (i_irq)
          next_st.state = RUNNING;
      end
      DMA_SERVICE:
      begin
        if (i_dma_done)
          next_st.state = WAITING;
      end
      HALTED: next_st.state = HALTED;
      default: ;
    endcase

    if (take)
    begin
      next_st.exec.done = 1'b1;
      next_st.exec.result = 16'h0000;
      next_st.exec.result_hi = 16'h0000;
      case (i_op.code)
        OP_ARITH_SHIFT_LEFT:
        begin
          res = w ? {a[14:0], 1'b0} : {8'h00, a[6:0], 1'b0};
          next_st.flags[C_BIT] = top_bit(a, w);
          next_st.flags[Z_BIT] = is_zero(res, w);
          next_st.flags[S_BIT] = top_bit(res, w);
          next_st.flags[V_BIT] = 1'b0;
          if (!w)
            next_st.flags[H_BIT] = a[3];
          next_st.exec.result = res;
        end
        OP_ARITH_SHIFT_RIGHT:
        begin
          res = w ? {a[15], a[15:1]} : {8'h00, a[7], a[7:1]};
          next_st.flags[C_BIT] = a[0];
          next_st.flags[S_BIT] = top_bit(res, w);
          next_st.flags[V_BIT] = 1'b0;
          if (!w)
          begin
            next_st.flags[Z_BIT] = is_zero(res, w);
            next_st.flags[H_BIT] = a[4];
          end
          next_st.exec.result = res;
        end
        OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY:
        begin
          if (i_op.code == OP_ROTATE_RIGHT_CARRY)
          begin
            res = w ? {cin, a[15:1]} : {8'h00, cin, a[7:1]};
            next_st.flags[C_BIT] = a[0];
          end
          else
          begin
            res = w ? {a[14:0], cin} : {8'h00, a[6:0], cin};
            next_st.flags[C_BIT] = top_bit(a, w);
          end
          next_st.flags[S_BIT] = top_bit(res, w);
          next_st.flags[V_BIT] = top_bit(res, w) ^ top_bit(a, w);
          if (!w)
            next_st.flags[Z_BIT] = is_zero(res, w);
          next_st.exec.result = res;
        end
        OP_DIVIDE:
        begin
          // Divide by zero cannot produce a quotient; it is reported on carry
          if (i_op.b[7:0] == 8'h00)
          begin
            next_st.flags[C_BIT] = 1'b1;
            next_st.exec.result = a;
          end
          else
          begin
            quot = a / {8'h00, i_op.b[7:0]};
            res = a % {8'h00, i_op.b[7:0]};
            next_st.flags[C_BIT] = 1'b0;
            next_st.flags[V_BIT] = (quot[15:8] != 8'h00);
            next_st.flags[Z_BIT] = (quot[7:0] == 8'h00);
            next_st.flags[S_BIT] = quot[7];
            next_st.exec.result = {res[7:0], quot[7:0]};
          end
        end
        OP_STEPPED_WORD_DIVIDE:
        begin
          // One restoring step: remainder in a, quotient in b, divisor in c
          trial = {a, i_op.b[15]} - {1'b0, i_op.c};
          if (!trial[16])
          begin
            next_st.exec.result_hi = trial[15:0];
            next_st.exec.result = {i_op.b[14:0], 1'b1};
          end
          else
          begin
            next_st.exec.result_hi = {a[14:0], i_op.b[15]};
            next_st.exec.result = {i_op.b[14:0], 1'b0};
          end
        end
        OP_SYS_PUSH, OP_SYS_PUSH_EA, OP_CALL:
        begin
          next_st.sys_sp = st.sys_sp - ((w || i_op.code != OP_SYS_PUSH) ? WORD_STEP
            : BYTE_STEP);
          next_st.exec.stack_access = 1'b1;
          next_st.exec.stack_addr = next_st.sys_sp;
          next_st.exec.result = a;
          next_st.exec.branch = (i_op.code == OP_CALL);
        end
        OP_SYS_POP:
        begin
          next_st.sys_sp = st.sys_sp + (w ? WORD_STEP : BYTE_STEP);
          next_st.exec.stack_access = 1'b1;
          next_st.exec.stack_addr = st.sys_sp;
        end
        OP_USER_PUSH, OP_USER_PUSH_EA:
        begin
          next_st.user_sp = st.user_sp - ((w || i_op.code == OP_USER_PUSH_EA) ? WORD_STEP
            : BYTE_STEP);
          next_st.exec.stack_access = 1'b1;
          next_st.exec.stack_addr = next_st.user_sp;
          next_st.exec.result = a;
        end
        OP_USER_POP:
        begin
          next_st.user_sp = st.user_sp + (w ? WORD_STEP : BYTE_STEP);
          next_st.exec.stack_access = 1'b1;
          next_st.exec.stack_addr = st.user_sp;
        end
        OP_CMP_BRANCH_FALSE, OP_CMP_BRANCH_TRUE:
        begin
          if (eq == (i_op.code == OP_CMP_BRANCH_TRUE))
            next_st.exec.branch = 1'b1;
          else
          begin
            next_st.exec.postinc = 1'b1;
            next_st.exec.result = i_op.c + 16'h0001;
          end
        end
        OP_BIT_BRANCH_FALSE: next_st.exec.branch = !a[i_op.bitsel];
        OP_BIT_BRANCH_TRUE: next_st.exec.branch = a[i_op.bitsel];
        OP_LOOP_REG:
        begin
          res = {8'h00, a[7:0] - 8'h01};
          next_st.exec.result = res;
          next_st.exec.branch = (res[7:0] != 8'h00);
        end
        OP_LOOP_PAIR:
        begin
          res = a - 16'h0001;
          next_st.exec.result = res;
          next_st.exec.branch = (res != 16'h0000);
        end
        OP_COND_BRANCH: next_st.exec.branch = cond_met(i_op.cc, st.flags);
        OP_JUMP: next_st.exec.branch = 1'b1;
        OP_INTERRUPT_RETURN:
          next_st.flags[C_BIT:H_BIT] = i_op.saved_flags[C_BIT:H_BIT];
        OP_WAIT: next_st.state = WAITING;
        OP_HALT: next_st.state = HALTED;
        OP_SET_LONG_PTR:
        begin
          next_st.rp_low = a[7:0] & LONG_RP_MASK;
          next_st.rp_high = (a[7:0] & LONG_RP_MASK) | HIGH_HALF_OFS;
        end
        OP_SET_LOW_PTR: next_st.rp_low = a[7:0] & HALF_RP_MASK;
        OP_SET_HIGH_PTR: next_st.rp_high = a[7:0] & HALF_RP_MASK;
        OP_CARRY_SET: next_st.flags[C_BIT] = 1'b1;
        OP_CARRY_CLEAR: next_st.flags[C_BIT] = 1'b0;
        OP_CARRY_INVERT: next_st.flags[C_BIT] = !st.flags[C_BIT];
        OP_SELECT_MEM: next_st.flags[PD_BIT] = a[0];
        default: ;
      endcase
    end
    // Registered so the acknowledge pin comes straight from a flip-flop
    next_st.dma_ack = (next_st.state == DMA_SERVICE);
  end

  //****************************************************************************
  // Registers and outputs
  //****************************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_exec = st.exec;
  assign o_rdata = st.rdata;
  assign o_flags = st.flags;
  assign o_mem_space = st.flags[PD_BIT];
  assign o_dma_ack = st.dma_ack;
  assign o_state = st.state;

  //****************************************************************************
  // Assertions
  //****************************************************************************
  logic take_a;
  assign take_a = i_op.valid && (st.state == RUNNING) && !i_bus.wr;
  logic eq_a;
  assign eq_a = i_op.word ? (i_op.a == i_op.b) : (i_op.a[7:0] == i_op.b[7:0]);

  flag_read_back_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_bus.rd && i_bus.addr == FLAG_REG_ADDR && !take_a |=> o_rdata == $past(o_flags))
    else $error("flag register read mismatch");

  shift_left_v_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && i_op.code == OP_ARITH_SHIFT_LEFT |=> !o_flags[V_BIT] && o_exec.done)
    else $error("left shift left overflow set");

  word_sra_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && i_op.code == OP_ARITH_SHIFT_RIGHT && i_op.word |=>
    o_flags[Z_BIT] == $past(o_flags[Z_BIT]) && o_flags[C_BIT] == $past(i_op.a[0]))
    else $error("word right shift flags wrong");

  sys_stack_flags_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && (i_op.code == OP_SYS_PUSH || i_op.code == OP_SYS_POP) |=>
    $stable(o_flags) && o_exec.stack_access)
    else $error("system stack changed flags");

  user_stack_sep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && i_op.code == OP_USER_PUSH |=> $stable(st.sys_sp) && $stable(o_flags))
    else $error("user stack touched system stack");

  cmp_false_branch_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && i_op.code == OP_CMP_BRANCH_FALSE |=>
    o_exec.branch != o_exec.postinc && o_exec.branch == !$past(eq_a))
    else $error("compare branch false wrong");

  loop_reg_branch_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && i_op.code == OP_LOOP_REG && i_op.a[7:0] == 8'h01 |=> !o_exec.branch)
    else $error("loop branched on zero");

  halt_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == HALTED |=> o_state == HALTED [*3])
    else $error("halt left without reset");

  wait_dma_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_state == WAITING && i_dma_req |=> o_dma_ack ##1 (o_dma_ack || o_state == WAITING))
    else $error("dma in wait mishandled");

  carry_invert_a: assert property (@(posedge i_clk) disable iff (i_rst)
    take_a && i_op.code == OP_CARRY_INVERT |=>
    o_flags[C_BIT] != $past(o_flags[C_BIT]) && o_flags[6:0] == $past(o_flags[6:0]))
    else $error("carry invert wrong");

  wait_cov: cover property (@(posedge i_clk) o_state == WAITING ##1 o_dma_ack);
  branch_cov: cover property (@(posedge i_clk) o_exec.branch);
  halt_cov: cover property (@(posedge i_clk) o_state == HALTED);
endmodule

//--- flag_exec_pkg.sv
//******************************************************************************
// Purpose: Constants, types and carriers for the flag-effect execution unit
// Assumes: Byte-wide register port, one instruction offered per cycle
// Notes on behaviour
// - Flags live at register-file location 231.
// - Carry, zero, sign, overflow, decimal, half-carry are flags.
// - Left shift sets C Z S, clears V.
// - Right shift byte updates CZSVH; word CSV.
// - Rotates through carry update C S V, Z byte.
// - Byte divide and stepped word divide; latter undefined.
// - System stack push and pop keep flags.
// - Separate user stack, flags untouched.
// - Compare branch false, else pointer post-increment.
// - Compare branch true, else pointer post-increment.
// - Bit test branches on bit false or true.
// - Register loop decrements, branches on non-zero.
// - Pair loop decrements word, branches on non-zero.
// - Conditional jumps on condition; unconditional always jump.
// - Wait stops execution until enabled interrupt.
// - DMA request during wait serviced, then wait.
// - Halt stops execution, interrupts and DMA until reset.
// - Long pointer selects sixteen working registers.
// - Low pointer sets lower eight registers base.
// - High pointer sets upper eight registers base.
// - Bit 1 spare flag, bit 0 memory selector.
// - Conditions look only at C, Z, S, V.
//******************************************************************************
package flag_exec_pkg;
  // Register map
  localparam logic [7:0] FLAG_REG_ADDR = 8'hE7;
  localparam logic [7:0] RP_LOW_ADDR = 8'hE8;
  localparam logic [7:0] RP_HIGH_ADDR = 8'hE9;
  localparam logic [7:0] SYS_SP_ADDR = 8'hEA;
  localparam logic [7:0] USER_SP_ADDR = 8'hEB;
  localparam logic [7:0] STATUS_ADDR = 8'hEC;
  // Flag bit positions
  localparam int C_BIT = 7;
  localparam int Z_BIT = 6;
  localparam int S_BIT = 5;
  localparam int V_BIT = 4;
  localparam int D_BIT = 3;
  localparam int H_BIT = 2;
  localparam int SPARE_BIT = 1;
  localparam int PD_BIT = 0;
  // Pointer masks and stack steps
  localparam logic [7:0] LONG_RP_MASK = 8'hF0;
  localparam logic [7:0] HALF_RP_MASK = 8'hF8;
  localparam logic [7:0] HIGH_HALF_OFS = 8'h08;
  localparam logic [7:0] BYTE_STEP = 8'h01;
  localparam logic [7:0] WORD_STEP = 8'h02;
  // Condition codes
  localparam logic [3:0] CC_FALSE = 4'h0;
  localparam logic [3:0] CC_TRUE = 4'h1;
  localparam logic [3:0] CC_C = 4'h2;
  localparam logic [3:0] CC_NC = 4'h3;
  localparam logic [3:0] CC_Z = 4'h4;
  localparam logic [3:0] CC_NZ = 4'h5;
  localparam logic [3:0] CC_PL = 4'h6;
  localparam logic [3:0] CC_MI = 4'h7;
  localparam logic [3:0] CC_OV = 4'h8;
  localparam logic [3:0] CC_NOV = 4'h9;
  localparam logic [3:0] CC_GE = 4'hA;
  localparam logic [3:0] CC_LT = 4'hB;
  localparam logic [3:0] CC_GT = 4'hC;
  localparam logic [3:0] CC_LE = 4'hD;
  localparam logic [3:0] CC_UGT = 4'hE;
  localparam logic [3:0] CC_ULE = 4'hF;

  typedef enum logic [4:0] {
    OP_NOP, OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_ROTATE_RIGHT_CARRY,
    OP_ROTATE_LEFT_CARRY, OP_DIVIDE, OP_STEPPED_WORD_DIVIDE, OP_SYS_PUSH, OP_SYS_POP,
    OP_SYS_PUSH_EA, OP_USER_PUSH, OP_USER_POP, OP_USER_PUSH_EA, OP_CMP_BRANCH_FALSE,
    OP_CMP_BRANCH_TRUE, OP_BIT_BRANCH_FALSE, OP_BIT_BRANCH_TRUE, OP_LOOP_REG,
    OP_LOOP_PAIR, OP_COND_BRANCH, OP_JUMP, OP_CALL, OP_INTERRUPT_RETURN, OP_WAIT,
    OP_HALT, OP_SET_LONG_PTR, OP_SET_LOW_PTR, OP_SET_HIGH_PTR, OP_CARRY_SET,
    OP_CARRY_CLEAR, OP_CARRY_INVERT, OP_SELECT_MEM
  } opcode_t;

  typedef enum logic [1:0] {RUNNING, WAITING, DMA_SERVICE, HALTED} cpu_state_t;

  typedef struct packed {
    logic valid;
    opcode_t code;
    logic word;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [3:0] cc;
    logic [3:0] bitsel;
    logic [7:0] saved_flags;
  } instr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic done;
    logic branch;
    logic postinc;
    logic stack_access;
    logic [7:0] stack_addr;
    logic [15:0] result;
    logic [15:0] result_hi;
  } exec_out_t;
endpackage

//--- prog_mem.sv
// Purpose: Program memory model offering one instruction per fetch request
// Assumes: Fetch strobe one cycle long; lag adds idle cycles before the offer
// Notes: Between offers the operand lines churn, so stale fields never look settled
`timescale 1ns/1ps
module prog_mem
  import flag_exec_pkg::*;
(
  // Clock and control
  input wire logic i_clk,
  input wire logic i_fetch,
  input wire logic [1:0] i_lag,
  // Instruction stream
  input wire instr_t i_word,
  output instr_t o_op
);
  //****************************************
  // Offer logic
  //****************************************
  instr_t held;
  logic pend;
  logic [1:0] lag_cnt;

  initial
  begin
    o_op = '0;
    pend = 1'b0;
  end

  always @(posedge i_clk)
  begin
    if (pend && lag_cnt == 2'h0)
    begin
      o_op <= held;
      pend <= 1'b0;
    end
    else
    begin
      // Inverted idle pattern: a design that reads fields without valid sees junk
      o_op <= {1'b0, ~o_op[$bits(instr_t)-2:0]};
      if (pend)
        lag_cnt <= lag_cnt - 2'h1;
    end
    if (i_fetch)
    begin
      held <= i_word;
      pend <= 1'b1;
      lag_cnt <= i_lag;
    end
  end
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the flag-effect execution unit
// Assumes: Program memory model in front of the instruction port
// Notes: Expected flags are worked out here from the documented flag effects
`timescale 1ns/1ps
module testbench;
  import flag_exec_pkg::*;
  //****************************************
  // Signals and tables
  //****************************************
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] ev = 3'h0;
  logic fetch = 1'b0;
  logic [1:0] lag = 2'h0;
  instr_t word = '0;
  instr_t op;
  bus_req_t i_bus = '0;
  exec_out_t o_exec;
  exec_out_t ex;
  logic [7:0] o_rdata;
  logic [7:0] o_flags;
  logic o_mem_space;
  logic o_dma_ack;
  cpu_state_t o_state;
  logic took;
  logic expect_take = 1'b1;
  logic [7:0] f;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  opcode_t sop [7] = '{OP_SYS_PUSH, OP_SYS_PUSH, OP_SYS_POP, OP_SYS_PUSH_EA, OP_USER_PUSH,
    OP_USER_PUSH_EA, OP_USER_POP};
  logic [6:0] sw = 7'h2E;
  logic [7:0] sadr [7] = '{8'h7F, 8'h7D, 8'h7D, 8'h7D, 8'h3F, 8'h3D, 8'h3D};
  opcode_t bop [4] = '{OP_CMP_BRANCH_FALSE, OP_CMP_BRANCH_TRUE, OP_BIT_BRANCH_FALSE,
    OP_BIT_BRANCH_TRUE};
  logic [15:0] lin [4] = '{16'h0005, 16'h0001, 16'h0100, 16'h0001};
  logic [15:0] lres [4] = '{16'h0004, 16'h0000, 16'h00FF, 16'h0000};

  always #5 i_clk = ~i_clk;

  prog_mem i_mem (.i_clk(i_clk), .i_fetch(fetch), .i_lag(lag), .i_word(word), .o_op(op));
  flag_exec_unit i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_op(op), .o_exec(o_exec),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_irq(ev[0]), .i_dma_req(ev[1]),
    .i_dma_done(ev[2]), .o_flags(o_flags), .o_mem_space(o_mem_space),
    .o_dma_ack(o_dma_ack), .o_state(o_state));

  //****************************************
  // Tasks
  //****************************************
  task give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task do_reset();
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask

  task wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk) i_bus <= '{1'b1, 1'b0, addr, data};
    @(posedge i_clk) i_bus <= '0;
    #1;
  endtask

  task rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge i_clk) i_bus <= '{1'b0, 1'b1, addr, 8'h00};
    @(posedge i_clk) i_bus <= '0;
    #1;
    check(o_rdata, exp);
  endtask

  // Raise one core event for a single cycle: 0 interrupt, 1 DMA request, 2 DMA end
  task strobe(input int n);
    @(posedge i_clk) ev[n] <= 1'b1;
    @(posedge i_clk) ev[n] <= 1'b0;
    #1;
  endtask

  task automatic run(input opcode_t code, input logic w = 1'b0,
    input logic [15:0] a = 16'h0000, input logic [15:0] b = 16'h0000,
    input logic [3:0] cc = 4'h0, input logic [3:0] bs = 4'h0, input logic [7:0] sv = 8'h00,
    input logic [15:0] c = 16'h0000);
    instr_t ins;
    ins = '{1'b1, code, w, a, b, c, cc, bs, sv};
    @(posedge i_clk) fetch <= 1'b1;
    word <= ins;
    @(posedge i_clk) fetch <= 1'b0;
    took = 1'b0;
    for (int k = 0; k < 8 && !took; k++)
    begin
      @(posedge i_clk);
      #1;
      if (o_exec.done === 1'b1)
      begin
        took = 1'b1;
        ex = o_exec;
      end
    end
    check(took, expect_take);
  endtask

  function automatic logic cond_ok(input logic [3:0] cc, input logic [7:0] fl);
    logic sv;
    logic cz;
    logic [15:0] tab;
    sv = fl[S_BIT] ^ fl[V_BIT];
    cz = fl[C_BIT] | fl[Z_BIT];
    tab = {cz, !cz, fl[Z_BIT] | sv, !(fl[Z_BIT] | sv), sv, !sv, !fl[V_BIT], fl[V_BIT],
      fl[S_BIT], !fl[S_BIT], !fl[Z_BIT], fl[Z_BIT], !fl[C_BIT], fl[C_BIT], 1'b1, 1'b0};
    return tab[cc];
  endfunction

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      give_verdict();
    end
  end

  //****************************************
  // Main sequence
  //****************************************
  initial
  begin
    do_reset();
    check(o_state, RUNNING);
    rd(FLAG_REG_ADDR, 8'h00);
    rd(8'h10, 8'h00);
    wr(FLAG_REG_ADDR, 8'h03);
    rd(FLAG_REG_ADDR, 8'h03);
    check(o_mem_space, 1'b1);
    wr(FLAG_REG_ADDR, 8'h7E);
    check(o_mem_space, 1'b0);
    run(OP_CARRY_SET);
    check(o_flags, 8'hFE);
    run(OP_CARRY_CLEAR);
    check(o_flags, 8'h7E);
    run(OP_CARRY_INVERT);
    check(o_flags, 8'hFE);
    wr(FLAG_REG_ADDR, 8'h1C);
    run(OP_ARITH_SHIFT_LEFT, 1'b0, 16'h0081);
    check(ex.result[7:0], 8'h02);
    check(o_flags, 8'h88);
    run(OP_ARITH_SHIFT_RIGHT, 1'b0, 16'h0001);
    check(o_flags, 8'hC8);
    run(OP_ARITH_SHIFT_RIGHT, 1'b1, 16'h8000);
    check(ex.result, 16'hC000);
    check(o_flags, 8'h68);
    run(OP_ROTATE_RIGHT_CARRY, 1'b0, 16'h0001);
    check(o_flags, 8'hC8);
    run(OP_ROTATE_LEFT_CARRY, 1'b1, 16'h4000);
    check(ex.result, 16'h8001);
    check(o_flags, 8'h78);
    run(OP_DIVIDE, 1'b0, 16'h0064, 16'h0007);
    check(ex.result, 16'h020E);
    check(o_flags, 8'h08);
    run(OP_DIVIDE, 1'b0, 16'h1234, 16'h0000);
    check(ex.result, 16'h1234);
    check(o_flags[C_BIT], 1'b1);
    // Restoring step: remainder shifts in quotient msb, subtract divisor when it fits
    run(OP_STEPPED_WORD_DIVIDE, 1'b1, 16'h0010, 16'h8003, 4'h0, 4'h0, 8'h00, 16'h0011);
    check(ex.result, 16'h0007);
    check(ex.result_hi, 16'h0010);
    check(o_flags, 8'h88);
    run(OP_STEPPED_WORD_DIVIDE, 1'b1, 16'h0001, 16'h0000, 4'h0, 4'h0, 8'h00, 16'h0011);
    check(ex.result, 16'h0000);
    check(ex.result_hi, 16'h0002);
    wr(SYS_SP_ADDR, 8'h80);
    wr(USER_SP_ADDR, 8'h40);
    wr(FLAG_REG_ADDR, 8'hFC);
    for (int i = 0; i < 7; i++)
    begin
      run(sop[i], sw[i]);
      check(ex.stack_access, 1'b1);
      check(ex.stack_addr, sadr[i]);
      check(o_flags, 8'hFC);
    end
    rd(SYS_SP_ADDR, 8'h7D);
    rd(USER_SP_ADDR, 8'h3E);
    for (int i = 0; i < 8; i++)
    begin
      run(bop[i[2:1]], 1'b0, 16'h0010, i[0] ? 16'h0010 : 16'h0011, 4'h0, i[0] ? 4'h4 : 4'h5,
        8'h00, 16'h0020);
      check(ex.branch, i[1] == i[0]);
      if (!i[2])
        check(ex.postinc, i[1] != i[0]);
      if (!i[2] && i[1] != i[0])
        check(ex.result, 16'h0021);
      check(o_flags, 8'hFC);
    end
    for (int i = 0; i < 4; i++)
    begin
      run(i < 2 ? OP_LOOP_REG : OP_LOOP_PAIR, i >= 2, lin[i]);
      check(i < 2 ? ex.result[7:0] : ex.result, lres[i]);
      check(ex.branch, !i[0]);
      check(o_flags, 8'hFC);
    end
    for (int p = 0; p < 2; p++)
    begin
      f = p ? 8'h5C : 8'hAE;
      wr(FLAG_REG_ADDR, f);
      for (int k = 0; k < 16; k++)
      begin
        lag <= k[1:0];
        run(OP_COND_BRANCH, 1'b0, 16'h0000, 16'h0000, k[3:0]);
        check(ex.branch, cond_ok(k[3:0], f));
        check(o_flags, f);
      end
    end
    lag <= 2'h0;
    run(OP_JUMP);
    check(ex.branch, 1'b1);
    run(OP_CALL);
    check(ex.branch, 1'b1);
    run(OP_SET_LONG_PTR, 1'b0, 16'h0037);
    rd(RP_LOW_ADDR, 8'h30);
    rd(RP_HIGH_ADDR, 8'h38);
    run(OP_SET_LOW_PTR, 1'b0, 16'h004D);
    rd(RP_LOW_ADDR, 8'h48);
    rd(RP_HIGH_ADDR, 8'h38);
    run(OP_SET_HIGH_PTR, 1'b0, 16'h0095);
    rd(RP_HIGH_ADDR, 8'h90);
    rd(RP_LOW_ADDR, 8'h48);
    check(o_flags, 8'h5C);
    wr(FLAG_REG_ADDR, 8'h03);
    run(OP_INTERRUPT_RETURN, 1'b0, 16'h0000, 16'h0000, 4'h0, 4'h0, 8'hD4);
    check(o_flags, 8'hD7);
    run(OP_WAIT);
    check(o_state, WAITING);
    rd(STATUS_ADDR, 8'h01);
    expect_take = 1'b0;
    run(OP_CARRY_INVERT);
    check(o_flags, 8'hD7);
    expect_take = 1'b1;
    strobe(1);
    check(o_state, DMA_SERVICE);
    check(o_dma_ack, 1'b1);
    strobe(2);
    check(o_state, WAITING);
    check(o_dma_ack, 1'b0);
    strobe(0);
    check(o_state, RUNNING);
    run(OP_HALT);
    check(o_state, HALTED);
    strobe(0);
    check(o_state, HALTED);
    expect_take = 1'b0;
    run(OP_CARRY_SET);
    check(o_flags, 8'hD7);
    expect_take = 1'b1;
    do_reset();
    check(o_state, RUNNING);
    run(OP_CARRY_SET);
    check(o_flags, 8'h80);
    run(OP_SELECT_MEM, 1'b0, 16'h0001);
    check(o_mem_space, 1'b1);
    check(o_flags, 8'h81);
    give_verdict();
  end
endmodule
